// [design/qeo_stepper.sv]
/*
  Quadrature stepper: turns single steps into Gray-coded A/B and index.
  Assumes steps arrive over qeo_step_if at most one per step slot.
*/
`timescale 1ns/1ps
module qeo_stepper
  import qeo_pkg::*;
#(
  parameter int unsigned STEP_GAP = 4  // Least cycles between output steps
) (
  input  wire logic clk,       // 200 MHz clock
  input  wire logic resetn,    // Synchronous reset, active low
  qeo_step_if.dst   step,      // Step requests
  output logic [7:0] pos,      // Output position code
  output logic      quad_a,    // Channel A level
  output logic      quad_b,    // Channel B level
  output logic      index_hi   // Index level
);
  logic [15:0] gap_ff;
  logic [7:0]  pos_ff;
  logic [7:0]  nxt_pos;
  logic        a_ff;
  logic        b_ff;
  logic        i_ff;
  wire         take = step.valid && (gap_ff == 16'h0000);

  assign step.ready = (gap_ff == 16'h0000);
  assign nxt_pos    = take ? (step.dir_up ? pos_ff + 8'h01 : pos_ff - 8'h01) : pos_ff;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gap_ff <= 16'h0000;
      pos_ff <= INDEX_ANGLE;
      a_ff   <= 1'b0;
      b_ff   <= 1'b0;
      i_ff   <= 1'b0;
    end else begin
      gap_ff <= take ? 16'(STEP_GAP - 1) : (gap_ff != 16'h0000 ? gap_ff - 16'h0001 : gap_ff);
      pos_ff <= nxt_pos;
      // Gray sequence 00,01,11,10 keeps A and B a quarter period apart
      a_ff   <= nxt_pos[1];
      b_ff   <= nxt_pos[1] ^ nxt_pos[0];
      i_ff   <= (nxt_pos == INDEX_ANGLE);
    end
  end

  assign pos      = pos_ff;
  assign quad_a   = a_ff;
  assign quad_b   = b_ff;
  assign index_hi = i_ff;
endmodule // qeo_stepper

// [design/qeo_top.sv]
/*
  Incremental output generator with field alarms and power-up failure marker.
  Assumes angle_code comes from same-clock logic; chip_select_n and the field
  flags are asynchronous pins. Alarm pins are open drain with external pull-ups.
*/
`timescale 1ns/1ps
module qeo_top
  import qeo_pkg::*;
#(
  parameter int unsigned SAMPLE_CNT = SAMPLE_CYCLES,  // Cycles per sample period
  parameter int unsigned SETTLE_CNT = 20000,          // Offset compensation time in cycles
  parameter int unsigned STEP_GAP   = 4               // Cycles per output step
) (
  input  wire logic               clk,              // 200 MHz clock
  input  wire logic               resetn,           // Power-on reset, active low
  input  wire logic [qeo_pkg::ANGLE_W-1:0] angle_code,  // Computed angle, same clock
  input  wire logic               chip_select_n,    // Chip select pin, active low
  input  wire logic               field_bad,        // Field out of range, async
  input  wire logic               field_rising,     // Magnet approaching, async
  input  wire logic               field_falling,    // Magnet receding, async
  output logic                    quad_a,           // Channel A
  output logic                    quad_b,           // Channel B
  output logic                    quad_index,       // Index
  output logic                    field_rising_alarm_n_o,   // Rising alarm drive value
  output logic                    field_rising_alarm_n_oe,  // Rising alarm enable
  output logic                    field_falling_alarm_n_o,  // Falling alarm drive value
  output logic                    field_falling_alarm_n_oe  // Falling alarm enable
);
  import qeo_pkg::*;

  qeo_step_if step_bus();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change accepted when stage 2 and 3 agree
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  logic [3:0] pin_ff;
  wire  [3:0] pin_raw = {field_falling, field_rising, field_bad, chip_select_n};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_ff  <= 4'h1;
      s2_ff  <= 4'h1;
      s3_ff  <= 4'h1;
      pin_ff <= 4'h1;
    end else begin
      s1_ff  <= pin_raw;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff ^ s3_ff));
    end
  end

  wire cs_low = !pin_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequence
  qeo_state_t  state_ff;
  qeo_state_t  nxt_state;
  logic [31:0] settle_ff;
  wire         settle_done = (settle_ff == 32'(SETTLE_CNT));

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      QEO_FAIL_HOLD: if (cs_low) nxt_state = QEO_SETTLE;
      QEO_SETTLE:    if (settle_done) nxt_state = QEO_RUN;
      QEO_RUN:       nxt_state = QEO_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff  <= QEO_FAIL_HOLD;
      settle_ff <= 32'h0000_0000;
    end else begin
      state_ff  <= nxt_state;
      settle_ff <= (state_ff == QEO_SETTLE && !settle_done) ? settle_ff + 32'h1 : settle_ff;
    end
  end

  wire running = (state_ff == QEO_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Sample pacer: one angle sample per period, backlog of steps spread out
  logic [31:0]        tick_ff;
  logic [ANGLE_W-1:0] target_ff;
  logic [ANGLE_W-1:0] out_pos;
  wire                tick = (tick_ff == 32'(SAMPLE_CNT - 1));
  wire  [ANGLE_W-1:0] diff = target_ff - out_pos;  // Modulo, shortest way chosen by sign

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_ff   <= 32'h0000_0000;
      target_ff <= INDEX_ANGLE;
    end else begin
      tick_ff   <= tick ? 32'h0000_0000 : tick_ff + 32'h1;
      // Sampling starts only once running so the first sample aligns outputs
      if (tick && running)
        target_ff <= angle_code;
    end
  end

  // Every unit of difference becomes exactly one step; nothing is skipped
  assign step_bus.valid  = running && (diff != 8'h00);
  assign step_bus.dir_up = !diff[ANGLE_W-1];

  qeo_stepper #(
    .STEP_GAP (STEP_GAP)
  ) u_stepper (
    .clk      (clk),
    .resetn   (resetn),
    .step     (step_bus),
    .pos      (out_pos),
    .quad_a   (),
    .quad_b   (),
    .index_hi ()
  );

  // Recompute levels from position so gating can hold them high
  logic a_ff;
  logic b_ff;
  logic i_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      a_ff <= 1'b1;
      b_ff <= 1'b1;
      i_ff <= 1'b1;
    end else begin
      a_ff <= running ? out_pos[1] : 1'b1;
      b_ff <= running ? (out_pos[1] ^ out_pos[0]) : 1'b1;
      i_ff <= running ? (out_pos == INDEX_ANGLE) : 1'b1;
    end
  end

  assign quad_a     = a_ff;
  assign quad_b     = b_ff;
  assign quad_index = i_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Field alarms, open drain: enable high pulls the pin low
  logic rise_on_ff;
  logic fall_on_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rise_on_ff <= 1'b0;
      fall_on_ff <= 1'b0;
    end else begin
      rise_on_ff <= pin_ff[1] || (pin_ff[2] && !pin_ff[3]);
      fall_on_ff <= pin_ff[1] || (pin_ff[3] && !pin_ff[2]);
    end
  end

  assign field_rising_alarm_n_o   = 1'b0;
  assign field_falling_alarm_n_o  = 1'b0;
  assign field_rising_alarm_n_oe  = rise_on_ff;
  assign field_falling_alarm_n_oe = fall_on_ff;
endmodule // qeo_top

// [shared/qeo_pkg.sv]
/*
  Constants and types for the quadrature encoder output block.
  Assumes a single 200 MHz clock and an 8-bit angle code supplied by the
  angle computation logic once per sample period.
*/
// Summary of operation
// - One angle step spans the index pulse, two steps each half of a channel, four a period.
// - Channels A and B are a quarter period (90 electrical degrees) apart.
// - The pulse generator never drops and never adds a step, even at high speed.
// - The angle is sampled every 100 us and the outputs refreshed once per sample.
// - A multi-step move between samples is interpolated into single steps.
// - Output latency is one sample period, two when missing pulses are spread out.
// - Field out of range drives both field alarms low together.
// - Magnet approaching lowers only the rising alarm; moving away only the falling one.
// - In normal operation both field alarms float and read high via pull-ups.
// - Index is high only while both channels are low, or with both high while the failure marker holds.
// - After power-on all three outputs stay high until chip select goes low and offset compensation then ends.
// - If chip select is low at power-up, outputs stay high until offset compensation ends.
package qeo_pkg;
  localparam int unsigned CLK_FREQ_HZ       = 200_000_000;
  localparam int unsigned SAMPLE_PERIOD_US  = 100;
  localparam int unsigned SAMPLE_CYCLES     = CLK_FREQ_HZ / 1_000_000 * SAMPLE_PERIOD_US;
  localparam int unsigned ANGLE_W           = 8;
  localparam int unsigned STEP_W            = 9;
  localparam logic [7:0]  INDEX_ANGLE       = 8'h00;
  localparam logic [1:0]  QUAD_RESET        = 2'h0;

  typedef enum logic [1:0] {
    QEO_FAIL_HOLD,
    QEO_SETTLE,
    QEO_RUN
  } qeo_state_t;
endpackage

// [shared/qeo_step_if.sv]
/*
  Step request path between the sample pacer and the quadrature stepper.
  Assumes both ends share clk.
*/
`timescale 1ns/1ps
interface qeo_step_if;
  logic valid;   // One step requested
  logic dir_up;  // Step direction
  logic ready;   // Stepper takes the step
  modport src (output valid, output dir_up, input ready);
  modport dst (input valid, input dir_up, output ready);
endinterface

// [sim/qeo_counter.sv]
/*
  Receiver model: an up/down counter fed by A, B and index.
  Assumes steps at least two clocks apart.
*/
`timescale 1ns/1ps
module qeo_counter (
  input  wire logic       clk,         // Clock
  input  wire logic       resetn,      // Reset, active low
  input  wire logic       quad_a,      // Channel A
  input  wire logic       quad_b,      // Channel B
  input  wire logic       quad_index,  // Index
  output logic      [7:0] count_ff,    // Tracked position
  output logic            supply_fail  // All three high
);
  logic [1:0] prev_ff;
  wire  [1:0] cur = {quad_a, quad_a ^ quad_b};
  assign supply_fail = quad_a & quad_b & quad_index;
  always_ff @(posedge clk) begin
    prev_ff <= cur;
    // Failure marker discards the count, as a real receiver should
    if (!resetn || supply_fail) count_ff <= 8'h00;
    else if (cur == prev_ff + 2'h1) count_ff <= count_ff + 8'h01;
    else if (cur == prev_ff - 2'h1) count_ff <= count_ff - 8'h01;
  end
endmodule // qeo_counter

// [sim/qeo_top_monitor.sv]
/*
  Checker for qeo_top, bound to every instance.
  Assumes STEP_GAP of at least 4 and a settle of more than 8 cycles.
*/
`timescale 1ns/1ps
module qeo_top_monitor (
  input wire logic clk,                      // Clock
  input wire logic resetn,                   // Reset, active low
  input wire logic chip_select_n,            // Chip select
  input wire logic field_bad,                // Field out of range
  input wire logic field_rising,             // Magnet approaching
  input wire logic field_falling,            // Magnet receding
  input wire logic quad_a,                   // Channel A
  input wire logic quad_b,                   // Channel B
  input wire logic quad_index,               // Index
  input wire logic field_rising_alarm_n_oe,  // Rising alarm enable
  input wire logic field_falling_alarm_n_oe  // Falling alarm enable
);
  logic cs_seen_ff;
  wire  all_hi = quad_a & quad_b & quad_index;
  wire  r_oe = field_rising_alarm_n_oe;
  wire  f_oe = field_falling_alarm_n_oe;
  always_ff @(posedge clk) begin
    if (!resetn) cs_seen_ff <= 1'b0;
    else if (!chip_select_n) cs_seen_ff <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // The jump out of the failure marker moves both channels at once
  sequence s_step;
    $changed({quad_a, quad_b}) && !$past(all_hi);
  endsequence
  sequence s_quiet;
    (!field_bad && !field_rising && !field_falling)[*8];
  endsequence
  a_index_both_low: assert property (quad_index |-> quad_a == quad_b)
    else $error("index with one channel high");
  a_gray_one_bit: assert property (s_step |->
    $countones({quad_a, quad_b} ^ $past({quad_a, quad_b})) == 1) else $error("not gray");
  a_step_gap_held: assert property (s_step |=> $stable({quad_a, quad_b})[*3])
    else $error("step too short");
  a_hold_high: assert property (!cs_seen_ff |-> all_hi)
    else $error("marker lost before select");
  a_settle_high: assert property ($rose(cs_seen_ff) |-> all_hi[*8])
    else $error("marker lost during settle");
  a_both_alarms: assert property (field_bad[*8] |-> r_oe && f_oe)
    else $error("both alarms not low");
  a_rise_only: assert property ((field_rising && !field_bad && !field_falling)[*8]
    |-> r_oe && !f_oe) else $error("rising alarm wrong");
  a_fall_only: assert property ((field_falling && !field_bad && !field_rising)[*8]
    |-> !r_oe && f_oe) else $error("falling alarm wrong");
  a_alarm_float: assert property (s_quiet |-> !r_oe && !f_oe)
    else $error("alarm driven when quiet");
endmodule // qeo_top_monitor
bind qeo_top qeo_top_monitor u_mon (.clk(clk), .resetn(resetn), .chip_select_n(chip_select_n),
  .field_bad(field_bad), .field_rising(field_rising), .field_falling(field_falling),
  .quad_a(quad_a), .quad_b(quad_b), .quad_index(quad_index),
  .field_rising_alarm_n_oe(field_rising_alarm_n_oe),
  .field_falling_alarm_n_oe(field_falling_alarm_n_oe));

// [sim/qeo_top_tb_top.sv]
/*
  Bench for qeo_top with a counter model on its outputs.
  Assumes 64-cycle samples, 16-cycle settle, pull-ups on the alarm pins.
*/
`timescale 1ns/1ps
module qeo_top_tb_top;
  logic        clk = 1'b0, resetn = 1'b0, cs_n = 1'b1, bad = 1'b0, ris = 1'b0, fal = 1'b0;
  logic  [7:0] angle = 8'h00, cnt;
  logic        a, b, idx, ro, roe, fo, foe, sfail, stb = 1'b0;
  logic [12:0] exp_q[$];
  logic  [2:0] stim[4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  logic  [1:0] pin_exp[4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  int          err_count = 0, checks = 0;
  wire         rpin = roe ? ro : 1'b1;
  wire         fpin = foe ? fo : 1'b1;
  always #2.5 clk = ~clk;
  qeo_top #(.SAMPLE_CNT(64), .SETTLE_CNT(16), .STEP_GAP(4)) dut (.clk(clk), .resetn(resetn),
    .angle_code(angle), .chip_select_n(cs_n), .field_bad(bad), .field_rising(ris),
    .field_falling(fal), .quad_a(a), .quad_b(b), .quad_index(idx),
    .field_rising_alarm_n_o(ro), .field_rising_alarm_n_oe(roe),
    .field_falling_alarm_n_o(fo), .field_falling_alarm_n_oe(foe));
  qeo_counter rx (.clk(clk), .resetn(resetn), .quad_a(a), .quad_b(b), .quad_index(idx),
    .count_ff(cnt), .supply_fail(sfail));
  function automatic logic [12:0] expv(logic [7:0] p, logic [1:0] pins, logic hold);
    expv = hold ? {3'h7, 8'h00, pins} : {p[1], p[1] ^ p[0], p == 8'h00, p, pins};
  endfunction
  task automatic check(string name, logic [12:0] seen, logic [12:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic note(logic [12:0] e);
    exp_q.push_back(e);
    stb <= 1'b1;
    @(posedge clk) stb <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (stb === 1'b1) check("outputs", {a, b, idx, cnt, rpin, fpin}, exp_q.pop_front());
  end
  initial begin
    #50000;
    err_count++;
    finish_test();
  end
  initial begin
    int p;
    int d;
    void'($urandom(8));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (30) @(posedge clk);
    note(expv(8'h00, 2'h3, 1'b1));
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    note(expv(8'h00, 2'h3, 1'b1));
    $display("test hold done");
    p = 0;
    // First two moves wrap below zero and come back onto the index
    for (int i = 0; i < 12; i++) begin
      d = (i < 2) ? 24 * i - 12 : int'($urandom % 25) - 12;
      p = (p + d) & 8'hff;
      angle <= p[7:0];
      repeat (2 * 64 + 16) @(posedge clk);
      note(expv(p[7:0], 2'h3, 1'b0));
    end
    $display("test moves done");
    for (int k = 0; k < 4; k++) begin
      {bad, ris, fal} <= stim[k];
      repeat (10) @(posedge clk);
      note(expv(p[7:0], pin_exp[k], 1'b0));
    end
    $display("test alarms done");
    finish_test();
  end
endmodule // qeo_top_tb_top
